// >>> core/irci_pkg.sv
// Purpose: Shared constants and types for the IR commissioning interpreter
// Assumes: 250 MHz aclk, AXI4-Lite register access, 32-bit data
// Notes:   Offsets are byte addresses of aligned words
package irci_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ          = 250_000_000;
  localparam int unsigned KEY_GAP_MS      = 1000;
  localparam int unsigned KEY_GAP_CYC     = CLK_HZ / 1000 * KEY_GAP_MS;
  localparam int unsigned HOUR_S          = 3600;
  // One hour of cycles exceeds 32 bits, so it is kept at 64
  localparam longint unsigned HOUR_CYC    = longint'(CLK_HZ) * HOUR_S;
  localparam int unsigned BLINK_MS        = 250;
  localparam int unsigned BLINK_CYC       = CLK_HZ / 1000 * BLINK_MS;
  localparam logic [6:0]  BURN_HOURS      = 7'h64;

  // Fast mode scales timers to one tenth
  localparam logic [3:0]  FAST_DIV        = 4'ha;

  // Key codes: digits 0..9 plus function keys
  localparam logic [3:0]  KEY_GROUP       = 4'ha;
  localparam logic [3:0]  KEY_BURN        = 4'hb;
  localparam logic [3:0]  KEY_9           = 4'h9;
  localparam logic [3:0]  KEY_1           = 4'h1;
  localparam logic [3:0]  KEY_3           = 4'h3;
  localparam logic [3:0]  KEY_7           = 4'h7;

  // Address and group limits
  localparam logic [6:0]  NO_ADDR         = 7'h7f;
  localparam logic [4:0]  MAX_GROUP       = 5'h0f;
  localparam logic [6:0]  MAX_ADDR        = 7'h3f;

  // Register byte offsets
  localparam logic [7:0]  REG_STATUS      = 8'h00;
  localparam logic [7:0]  REG_ADDR        = 8'h04;
  localparam logic [7:0]  REG_GROUPS      = 8'h08;
  localparam logic [7:0]  REG_BURN_HRS    = 8'h0c;
  localparam logic [7:0]  REG_CTRL        = 8'h10;
  localparam logic [7:0]  REG_TOOL_ADDR   = 8'h14;

  // Status field positions
  localparam int unsigned ST_FAST         = 0;
  localparam int unsigned ST_BURN         = 1;
  localparam int unsigned ST_HAS_ADDR     = 2;
  localparam int unsigned ST_BLINK        = 3;
  localparam int unsigned ST_IDLE         = 4;

  // Control field positions
  localparam int unsigned CT_WC           = 0;
  localparam int unsigned CT_COMM         = 1;
  localparam int unsigned CT_PRES_EN      = 2;
  localparam int unsigned CT_CLR_ADDR     = 3;

  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  typedef enum logic [2:0] {
    IRCI_IDLE, IRCI_ADDR9, IRCI_ADDR_D1, IRCI_ADDR_D2,
    IRCI_GROUP, IRCI_FAST3, IRCI_FAST7, IRCI_FAST9
  } irci_state_t;

  // Lamp restriction bundle
  typedef struct packed {
    logic no_dim_p1;
    logic no_dim_p2;
    logic sensor_off;
    logic presence_sw;
  } irci_lamp_t;

endpackage

// >>> core/irci_top.sv
// Purpose: IR commissioning key interpreter with AXI4-Lite registers
// Assumes: Key strobes are synchronous to aclk; port1_on is a pin
// Notes:   Blink requests leave as a count with a strobe
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module irci_top
  import irci_pkg::*;
#(
  parameter int unsigned GAP_CYC  = KEY_GAP_CYC, // Key gap limit
  parameter longint unsigned HOUR_LEN = HOUR_CYC // Cycles per hour
) (
  input  wire logic        aclk,          // Clock
  input  wire logic        aresetn,       // Sync reset, low
  input  wire logic        ce,            // Clock enable
  input  wire logic        key_valid,     // Decoded key strobe
  input  wire logic [3:0]  key_code,      // Decoded key
  input  wire logic        port1_on,      // Port one lamps lit, pin
  input  wire logic        cal_active,    // Set point calibration busy
  input  wire logic [31:0] s_axi_awaddr,  // AXI write address
  input  wire logic        s_axi_awvalid, // AXI
  output logic             s_axi_awready, // AXI
  input  wire logic [31:0] s_axi_wdata,   // AXI
  input  wire logic [3:0]  s_axi_wstrb,   // AXI
  input  wire logic        s_axi_wvalid,  // AXI
  output logic             s_axi_wready,  // AXI
  output logic [1:0]       s_axi_bresp,   // AXI
  output logic             s_axi_bvalid,  // AXI
  input  wire logic        s_axi_bready,  // AXI
  input  wire logic [31:0] s_axi_araddr,  // AXI
  input  wire logic        s_axi_arvalid, // AXI
  output logic             s_axi_arready, // AXI
  output logic [31:0]      s_axi_rdata,   // AXI
  output logic [1:0]       s_axi_rresp,   // AXI
  output logic             s_axi_rvalid,  // AXI
  input  wire logic        s_axi_rready,  // AXI
  output logic             fast_mode,     // Timers at one tenth
  output logic [3:0]       timer_div,     // Timer divisor
  output logic             blink_stb,     // Blink request pulse
  output logic [1:0]       blink_cnt,     // Blinks requested
  output irci_lamp_t       lamp           // Lamp restrictions
);

  ////////////////////////////////////////////////////////////////////////
  // State
  irci_state_t state_r;
  logic [31:0] gap_r;
  logic [3:0]  dig_r;
  logic [6:0]  addr_r;
  logic [15:0] groups_r;
  logic        burn_r;
  logic [6:0]  hours_r;
  logic [39:0] hcnt_r;      // Holds one full hour of cycles
  logic [2:0]  p1_sync_r;
  logic        p1_on_r;
  logic [3:0]  ctrl_r;
  logic        addr_stb, grp_stb, fast_stb, burn_stb, tool_stb;
  logic [6:0]  new_addr;
  logic [3:0]  new_grp;
  logic        timeout;
  logic        wr_fire, rd_fire;
  logic [7:0]  wr_off;

  function automatic logic is_digit(input logic [3:0] k);
    is_digit = (k <= 4'h9);
  endfunction

  assign timeout = (state_r != IRCI_IDLE) && (gap_r >= GAP_CYC);

  ////////////////////////////////////////////////////////////////////////
  // Key sequence machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= IRCI_IDLE;
      dig_r   <= 4'h0;
    end else if (ce) begin
      if (timeout) begin
        state_r <= IRCI_IDLE;
      end else if (key_valid) begin
        unique case (state_r)
          IRCI_IDLE: begin
            if (key_code == KEY_9) state_r <= IRCI_ADDR9;
            else if (key_code == KEY_1) state_r <= IRCI_FAST3;
            else if (key_code == KEY_GROUP) state_r <= IRCI_GROUP;
          end
          IRCI_ADDR9: begin
            // Second 9 opens address entry
            state_r <= (key_code == KEY_9) ? IRCI_ADDR_D1 : IRCI_IDLE;
          end
          IRCI_ADDR_D1: begin
            dig_r   <= key_code;
            state_r <= is_digit(key_code) ? IRCI_ADDR_D2 : IRCI_IDLE;
          end
          IRCI_ADDR_D2: state_r <= IRCI_IDLE;
          IRCI_GROUP: begin
            // A first 1 may open 10..15, so wait for one more digit;
            // any other key closes the group entry either way
            if (dig_r == 4'hf && key_code == 4'h1) begin
              dig_r   <= 4'h1;
              state_r <= IRCI_GROUP;
            end else begin
              state_r <= IRCI_IDLE;
            end
          end
          IRCI_FAST3: state_r <= (key_code == KEY_3) ? IRCI_FAST7 : IRCI_IDLE;
          IRCI_FAST7: state_r <= (key_code == KEY_7) ? IRCI_FAST9 : IRCI_IDLE;
          IRCI_FAST9: state_r <= IRCI_IDLE;
        endcase
        if (state_r == IRCI_IDLE && key_code == KEY_GROUP) dig_r <= 4'hf;
      end
    end
  end

  // Group digit handling: a lone digit, or 1 then a second digit.
  // A lone 1 has no closing key, so the key gap completes group 1;
  // without this path group 1 could never be joined.
  // A digit that arrives together with the gap is too late.
  logic grp_done;
  logic [4:0] grp_val;
  always_comb begin
    grp_done = 1'b0;
    grp_val  = 5'h00;
    if (timeout && state_r == IRCI_GROUP && dig_r == 4'h1) begin
      grp_done = 1'b1;
      grp_val  = 5'h01;
    end else if (!timeout && state_r == IRCI_GROUP && key_valid
                 && is_digit(key_code)) begin
      if (dig_r == 4'h1) begin
        grp_done = 1'b1;
        grp_val  = 5'(5'h0a + {1'b0, key_code});
      end else if (key_code != 4'h1) begin
        grp_done = 1'b1;
        grp_val  = {1'b0, key_code};
      end
    end
  end

  // Sequence completion strobes
  always_comb begin
    addr_stb = ce && key_valid && !timeout && state_r == IRCI_ADDR_D2
               && is_digit(key_code);
    // Widen before the product: at four bits the tens would wrap
    new_addr = {3'h0, dig_r} * 7'h0a + {3'h0, key_code};
    grp_stb  = ce && grp_done
               && grp_val <= MAX_GROUP;
    new_grp  = grp_val[3:0];
    fast_stb = ce && key_valid && !timeout && state_r == IRCI_FAST9
               && key_code == KEY_9;
    burn_stb = ce && key_valid && state_r == IRCI_IDLE
               && key_code == KEY_BURN;
    tool_stb = ce && wr_fire && wr_off == REG_TOOL_ADDR;
  end

  // Cycles since the last key; cleared while idle
  // A lone 1 after the group key rides this counter to completion
  always_ff @(posedge aclk) begin
    if (!aresetn) gap_r <= 32'h0;
    else if (ce) begin
      if (key_valid || state_r == IRCI_IDLE) gap_r <= 32'h0;
      else gap_r <= gap_r + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_r <= NO_ADDR;
    end else if (addr_stb) begin
      addr_r <= new_addr;
    end else if (tool_stb) begin
      addr_r <= s_axi_wdata[6:0];
    end else if (ce && wr_fire && wr_off == REG_CTRL
                 && s_axi_wdata[CT_CLR_ADDR]) begin
      addr_r <= NO_ADDR;
    end
  end

  // Group membership; a key set and a bus clear in one cycle both act,
  // and the set wins on its own bit (later assignment)
  always_ff @(posedge aclk) begin
    if (!aresetn) groups_r <= 16'h0000;
    else if (ce) begin
      if (wr_fire && wr_off == REG_GROUPS)
        groups_r <= groups_r & ~s_axi_wdata[15:0];
      if (grp_stb) groups_r[new_grp] <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) fast_mode <= 1'b0;
    else if (fast_stb) fast_mode <= ~fast_mode;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) timer_div <= 4'h1;
    else if (ce) timer_div <= fast_mode ? FAST_DIV : 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Burn-in hour counter from port one state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p1_sync_r <= 3'h0;
      p1_on_r   <= 1'b0;
    end else if (ce) begin
      p1_sync_r <= {p1_sync_r[1:0], port1_on};
      if (p1_sync_r[2] == p1_sync_r[1]) p1_on_r <= p1_sync_r[2];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      burn_r  <= 1'b0;
      hours_r <= 7'h00;
      hcnt_r  <= 40'h0;
    end else if (ce) begin
      if (burn_stb) begin
        burn_r  <= ~burn_r;
        hours_r <= 7'h00;
        hcnt_r  <= 40'h0;
      end else if (burn_r && p1_on_r) begin
        // Hours only pass while port one lamps are lit
        if (hcnt_r >= 40'(HOUR_LEN - 64'd1)) begin
          hcnt_r <= 40'h0;
          if (hours_r == BURN_HOURS - 7'h01) begin
            burn_r  <= 1'b0;
            hours_r <= BURN_HOURS;
          end else hours_r <= hours_r + 7'h01;
        end else hcnt_r <= hcnt_r + 40'h1;
      end
    end
  end

  // Lamp restriction outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) lamp <= '0;
    else if (ce) begin
      lamp.no_dim_p1   <= burn_r && !cal_active && !ctrl_r[CT_COMM];
      lamp.no_dim_p2   <= burn_r && ctrl_r[CT_WC] && !cal_active
                          && !ctrl_r[CT_COMM];
      lamp.sensor_off  <= burn_r;
      lamp.presence_sw <= ctrl_r[CT_PRES_EN];
    end
  end

  // Blink acknowledgement
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blink_stb <= 1'b0;
      blink_cnt <= 2'h0;
    end else if (ce) begin
      blink_stb <= addr_stb | grp_stb | fast_stb | burn_stb;
      if (addr_stb || grp_stb) blink_cnt <= 2'h1;
      else if (fast_stb) blink_cnt <= fast_mode ? 2'h2 : 2'h1;
      else if (burn_stb) blink_cnt <= burn_r ? 2'h1 : 2'h2;
    end else blink_stb <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write: both channels taken together, then response
  assign wr_fire = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
                   && !s_axi_awready;
  assign wr_off  = s_axi_awaddr[7:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      ctrl_r        <= 4'h0;
    end else if (ce) begin
      s_axi_awready <= wr_fire;
      s_axi_wready  <= wr_fire;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        unique case (wr_off)
          REG_CTRL: begin
            if (s_axi_wstrb[0]) ctrl_r <= s_axi_wdata[3:0] & 4'h7;
            s_axi_bresp <= RESP_OKAY;
          end
          REG_GROUPS, REG_TOOL_ADDR: s_axi_bresp <= RESP_OKAY;
          default: s_axi_bresp <= RESP_SLVERR;
        endcase
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end

  // AXI4-Lite read
  assign rd_fire = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= rd_fire;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        unique case (s_axi_araddr[7:0])
          REG_STATUS: s_axi_rdata <= {27'h0, state_r == IRCI_IDLE,
                                      blink_stb, addr_r != NO_ADDR,
                                      burn_r, fast_mode};
          REG_ADDR:      s_axi_rdata <= {25'h0, addr_r};
          REG_GROUPS:    s_axi_rdata <= {16'h0, groups_r};
          REG_BURN_HRS:  s_axi_rdata <= {25'h0, hours_r};
          REG_CTRL:      s_axi_rdata <= {28'h0, ctrl_r};
          REG_TOOL_ADDR: s_axi_rdata <= {25'h0, addr_r};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// >>> testbench/irci_top_asserts.sv
// Purpose: Port checker for the IR commissioning interpreter
// Assumes: One aclk domain, synchronous active low reset
// Notes:   Bound into irci_top, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module irci_chk
  import irci_pkg::*;
(
  input wire logic       aclk,         // Clock
  input wire logic       aresetn,      // Reset, low
  input wire logic       ce,           // Clock enable
  input wire logic       key_valid,    // Key strobe
  input wire logic [3:0] key_code,     // Key
  input wire logic       cal_active,   // Calibration busy
  input wire logic       s_axi_bvalid, // Write response
  input wire logic       s_axi_bready, // Response taken
  input wire logic       fast_mode,    // Fast mode
  input wire logic [3:0] timer_div,    // Timer divisor
  input wire logic       blink_stb,    // Blink pulse
  input wire logic [1:0] blink_cnt,    // Blink count
  input wire irci_lamp_t lamp          // Lamp restrictions
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////
  // Blink requests of one and two flashes
  sequence s_blink1;
    blink_stb && blink_cnt == 2'h1;
  endsequence
  sequence s_blink2;
    blink_stb && blink_cnt == 2'h2;
  endsequence
  // Mode changes and their acknowledgements
  property p_div;
    ce |=> timer_div == ($past(fast_mode) ? FAST_DIV : 4'h1);
  endproperty
  property p_fast_on;
    $rose(fast_mode) |-> s_blink1;
  endproperty
  property p_fast_off;
    $fell(fast_mode) |-> s_blink2;
  endproperty
  property p_fast_cause;
    $changed(fast_mode) |-> $past(key_valid) && $past(key_code) == KEY_9;
  endproperty
  property p_blink_cause;
    blink_stb |-> $past(key_valid) || blink_cnt == 2'h1;
  endproperty
  // Lamp restriction relations and write response hold
  property p_cal;
    ce && cal_active |=> !lamp.no_dim_p1 && !lamp.no_dim_p2;
  endproperty
  property p_port2;
    lamp.no_dim_p2 |-> lamp.no_dim_p1;
  endproperty
  property p_sensor;
    lamp.no_dim_p1 |-> lamp.sensor_off;
  endproperty
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_div: assert property (p_div)
    else $error("timer divisor does not follow fast mode");
  a_fast_on: assert property (p_fast_on)
    else $error("fast mode entry without single blink");
  a_fast_off: assert property (p_fast_off)
    else $error("fast mode exit without double blink");
  a_fast_cause: assert property (p_fast_cause)
    else $error("fast mode changed without closing key");
  a_blink_cause: assert property (p_blink_cause)
    else $error("blink without a key the cycle before");
  a_cal: assert property (p_cal)
    else $error("calibration did not lift the dimming hold");
  a_port2: assert property (p_port2)
    else $error("port two held while port one free");
  a_sensor: assert property (p_sensor)
    else $error("light sensor active during dimming hold");
  a_bhold: assert property (p_bhold)
    else $error("write response dropped before taken");
endmodule
bind irci_top irci_chk i_chk (.aclk, .aresetn, .ce, .key_valid, .key_code,
  .cal_active, .s_axi_bvalid, .s_axi_bready, .fast_mode, .timer_div,
  .blink_stb, .blink_cnt, .lamp);
`default_nettype wire

// >>> testbench/irci_remote.sv
// Purpose: Behavioural model of the installer with the remote
// Assumes: Pauses given in aclk cycles
// Notes:   Code wanders between keys so no stale value sits there
`timescale 1ns/1ps
`default_nettype none
module irci_remote
  import irci_pkg::*;
(
  input  wire logic       aclk,      // Clock
  output logic            key_valid, // Key strobe
  output logic [3:0]      key_code   // Key
);
  ////////////////////////////////////////////////////////////////////////
  // Idle remote
  initial begin
    key_valid = 1'b0;
    key_code  = 4'h0;
  end
  // One key after the indicator settles, under the gap limit
  task automatic press(input logic [3:0] k, input int pause);
    repeat (pause) @(posedge aclk);
    key_valid <= 1'b1;
    key_code  <= k;
    @(posedge aclk);
    key_valid <= 1'b0;
    key_code  <= ~k;
  endtask
  // Forced address as two digits, leading zero below ten
  task automatic addr(input int a, input int pause);
    press(KEY_9, pause);
    press(KEY_9, pause);
    press(4'(a / 10), pause);
    press(4'(a % 10), pause);
  endtask
endmodule
`default_nettype wire

// >>> testbench/irci_top_bench.sv
// Purpose: Self-checking bench for the IR commissioning interpreter
// Assumes: Short gap and hour parameters for simulation
// Notes:   Random digits and pauses from a fixed xorshift seed
`timescale 1ns/1ps
`default_nettype none
module irci_top_bench
  import irci_pkg::*;
;
  logic        aclk, aresetn, ce, key_valid, port1_on, cal_active;
  logic [3:0]  key_code, timer_div, s_axi_wstrb;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, fast_mode, blink_stb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, blink_cnt, lastcnt;
  irci_lamp_t  lamp;
  logic [31:0] seed, g_exp;
  int          errors = 0, num_checks = 0, nblk = 0, i, a, g, n0;
  irci_top #(.GAP_CYC(20), .HOUR_LEN(10)) i_dut (
    .aclk, .aresetn, .ce, .key_valid, .key_code, .port1_on, .cal_active,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .fast_mode, .timer_div, .blink_stb, .blink_cnt, .lamp
  );
  irci_remote i_rem (.aclk, .key_valid, .key_code);
  ////////////////////////////////////////////////////////////////////////
  // Clock, 4 ns
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  // Count blink requests
  always @(posedge aclk) begin
    if (blink_stb === 1'b1) begin
      nblk    <= nblk + 1;
      lastcnt <= blink_cnt;
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Keys with random pauses under the gap limit
  task keys(input logic [3:0] q[$]);
    foreach (q[j]) i_rem.press(q[j], 2 + int'(xs() % 8));
    wait_clk(3);
  endtask
  task blinks(input int add, input logic [1:0] c);
    chk("blinks", nblk - n0, add);
    if (add > 0) chk("blink_cnt", lastcnt, c);
    n0 = nblk;
  endtask
  task wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr  <= {24'h0, ad};
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, r});
  endtask
  task rd(input string n, input logic [7:0] ad, input logic [31:0] m,
          input logic [31:0] e, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= {24'h0, ad};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(n, s_axi_rdata & m, e);
    chk("resp", {30'h0, s_axi_rresp}, {30'h0, r});
  endtask
  task wrap_up();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    wait_clk(20000);
    errors++;
    wrap_up();
  end
  // Main sequence
  initial begin
    {ce, s_axi_wstrb, aresetn, port1_on, cal_active, s_axi_awvalid} = 9'h0f0;
    {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 4'h0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
    seed = 32'h7f09;
    ce = 1'b1;
    wait_clk(20);
    aresetn <= 1'b1;
    rd("addr", REG_ADDR, 32'hff, 32'h7f, RESP_OKAY);
    rd("groups", REG_GROUPS, '1, 0, RESP_OKAY);
    rd("burn", REG_STATUS, 32'h2, 0, RESP_OKAY);
    rd("unmapped", 8'h40, '1, 0, RESP_SLVERR);
    chk("div", timer_div, 1);
    $display("test reset done");
    n0 = nblk;
    for (i = 0; i < 3; i++) begin
      a = (i == 0) ? 2 : int'(xs() % 100);
      i_rem.addr(a, 2 + int'(xs() % 8));
      wait_clk(3);
      blinks(1, 2'h1);
      rd("addr", REG_ADDR, 32'hff, a, RESP_OKAY);
    end
    keys({KEY_9, KEY_9, 4'h3});
    wait_clk(30);
    keys({KEY_9, 4'h5});
    blinks(0, 2'h0);
    rd("addr", REG_ADDR, 32'hff, a, RESP_OKAY);
    wr(REG_TOOL_ADDR, 32'h2a, RESP_OKAY);
    rd("tool", REG_ADDR, 32'hff, 32'h2a, RESP_OKAY);
    wr(REG_CTRL, 32'h8, RESP_OKAY);
    rd("clr", REG_ADDR, 32'hff, 32'h7f, RESP_OKAY);
    wr(8'h40, 32'h0, RESP_SLVERR);
    $display("test address done");
    g_exp = 0;
    for (i = 0; i < 5; i++) begin
      g = (i == 0) ? 15 : (i == 1) ? 0 : int'(xs() % 16);
      if (g < 10) keys({KEY_GROUP, 4'(g)});
      else keys({KEY_GROUP, 4'h1, 4'(g - 10)});
      if (g == 1) wait_clk(25); // Lone 1 completes on the key gap
      g_exp |= 32'h1 << g;
      blinks(1, 2'h1);
      rd("groups", REG_GROUPS, '1, g_exp, RESP_OKAY);
    end
    keys({KEY_GROUP, 4'h1, 4'h6});
    blinks(0, 2'h0);
    rd("groups", REG_GROUPS, '1, g_exp, RESP_OKAY);
    $display("test groups done");
    for (i = 0; i < 2; i++) begin
      keys({KEY_1, KEY_3, KEY_7, KEY_9});
      blinks(1, 2'(i + 1));
      chk("fast", fast_mode, i == 0);
      chk("div", timer_div, (i == 0) ? FAST_DIV : 4'h1);
    end
    keys({KEY_1, KEY_3});
    wait_clk(25);
    keys({KEY_7, KEY_9});
    blinks(0, 2'h0);
    chk("fast", fast_mode, 0);
    wait_clk(25);
    ce <= 1'b0;
    keys({KEY_BURN});
    ce <= 1'b1;
    blinks(0, 2'h0);
    $display("test fast done");
    keys({KEY_BURN});
    blinks(1, 2'h2);
    rd("burn", REG_STATUS, 32'h2, 32'h2, RESP_OKAY);
    wr(REG_CTRL, 32'h5, RESP_OKAY);
    wait_clk(4);
    chk("lamp", lamp, 4'hf);
    cal_active <= 1'b1;
    wait_clk(4);
    chk("no_dim", lamp.no_dim_p1, 0);
    cal_active <= 1'b0;
    port1_on   <= 1'b1;
    wait_clk(60);
    keys({KEY_BURN});
    blinks(1, 2'h1);
    rd("hours", REG_BURN_HRS, '1, 0, RESP_OKAY);
    keys({KEY_BURN});
    blinks(1, 2'h2);
    wait_clk(1200);
    rd("hours", REG_BURN_HRS, '1, 32'h64, RESP_OKAY);
    rd("burn", REG_STATUS, 32'h2, 0, RESP_OKAY);
    $display("test burn done");
    wrap_up();
  end
endmodule
`default_nettype wire
